// ===== src/tcc_regs.svh
// Named constants for the timer/counter capture-compare core
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
`define TCC_W          16
`define TCC_NCH        4
`define TCC_MSB        15
`define TCC_ZERO       16'h0000
`define TCC_ONE        16'h0001
`define TCC_PER_RST    16'hffff
`define TCC_POL_LIMIT  16'h8000
`define TCC_CLK_OFF    4'h0
`define TCC_PRE_ONE    10'h001
`define TCC_PRE_ZERO   10'h000
`define TCC_MASK_DIV1  10'h000
`define TCC_MASK_DIV2  10'h001
`define TCC_MASK_DIV4  10'h003
`define TCC_MASK_DIV8  10'h007
`define TCC_MASK_DIV64 10'h03f
`define TCC_MASK_DIV256 10'h0ff
`define TCC_MASK_DIV1K 10'h3ff
`endif

// ===== src/tcc_pkg.sv
// Types shared by the timer/counter capture-compare core
package tcc_pkg;
   typedef enum logic [2:0] {EVACT_OFF, EVACT_CAPT, EVACT_UPDOWN, EVACT_QDEC,
                             EVACT_FRQ, EVACT_PW} tcc_evact_t;
   typedef enum logic [1:0] {WGM_NORMAL, WGM_FRQ, WGM_SINGLE, WGM_DUAL} tcc_wgm_t;
   typedef struct packed {
      logic [3:0] clk_sel;
      logic [2:0] ev_sel;
      tcc_evact_t ev_act;
      tcc_wgm_t   wg_mode;
      logic [3:0] cc_en;
      logic       dir_down;
   } tcc_cfg_t;
   typedef struct packed {
      logic        cnt_wr;
      logic        per_wr;
      logic        perbuf_wr;
      logic [3:0]  cc_wr;
      logic [3:0]  ccbuf_wr;
      logic [15:0] data;
   } tcc_wr_t;
endpackage

// ===== src/tcc_chan.sv
// One compare/capture channel with its buffer and flags
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"
module tcc_chan (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   // Counter side
   input  wire logic               tick,
   input  wire logic               update,
   input  wire logic [15:0]        cnt,
   input  wire logic               cmp_mode,
   input  wire tcc_pkg::tcc_wgm_t  wgm,
   // Capture trigger
   input  wire logic               cap_trig,
   input  wire logic [15:0]        cap_val,
   // Software access
   input  wire logic               wr_val,
   input  wire logic               wr_buf,
   input  wire logic [15:0]        wr_data,
   input  wire logic               rd,
   input  wire logic               flag_clr,
   // Channel state
   output logic [15:0]             val,
   output logic [15:0]             buf_val,
   output logic                    bv,
   output logic                    flag,
   output logic                    match_evt,
   output logic                    err_evt,
   output logic                    wg
);
   logic        hit;
   logic        overrun;

   assign hit       = cmp_mode && tick && (cnt == val);
   assign overrun   = !cmp_mode && cap_trig && flag && bv;
   assign match_evt = hit;
   assign err_evt   = overrun;

   // R21: compare value follows buffer on update
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         val     <= `TCC_ZERO;
         buf_val <= `TCC_ZERO;
         bv      <= 1'b0;
      end else if (cmp_mode) begin
         if (wr_val)
            val <= wr_data;
         else if (update && bv)
            val <= buf_val;
         // R25: buffer write marks it valid
         if (wr_buf) begin
            buf_val <= wr_data;
            bv      <= 1'b1;
         end else if (update) begin
            bv <= 1'b0;
         end
      // R26: two-entry FIFO, R19 overrun drops value
      end else if (cap_trig && !overrun) begin
         if (!flag || (rd && !bv)) begin
            val <= cap_val;
         end else if (rd) begin
            val     <= buf_val;
            buf_val <= cap_val;
         end else begin
            buf_val <= cap_val;
            bv      <= 1'b1;
         end
      end else if (rd && bv) begin
         val <= buf_val;
         bv  <= 1'b0;
      end else if (wr_val) begin
         val <= wr_data;
      end else if (wr_buf) begin
         buf_val <= wr_data;
         bv      <= 1'b1;
      end
   end

   // R14 R20: flag set wins over clear or read
   always_ff @(posedge core_clk) begin
      if (sys_rst)
         flag <= 1'b0;
      else if (hit || (!cmp_mode && cap_trig))
         flag <= 1'b1;
      else if (flag_clr || (!cmp_mode && rd && !bv))
         flag <= 1'b0;
   end

   // Frequency mode toggles on match; other modes give a compare level
   always_ff @(posedge core_clk) begin
      if (sys_rst)
         wg <= 1'b0;
      else if (wgm == tcc_pkg::WGM_FRQ)
         wg <= wg ^ hit;
      else
         wg <= (cnt < val);
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_CMP_FLAG: assert property (hit |=> flag) // R20
      else $error("compare match did not set channel flag");
   AST_CAP_OVERRUN: assert property (overrun && !rd && !wr_val && !wr_buf // R19
      |=> $stable(val) && $stable(buf_val) && flag && bv)
      else $error("overrun capture was not discarded");
   AST_CMP_UPDATE: assert property (cmp_mode && update && bv && !wr_val && !wr_buf // R21
      |=> val == $past(buf_val) && !bv)
      else $error("compare value not loaded from buffer on update");
   AST_BUF_VALID: assert property (cmp_mode && wr_buf |=> bv && buf_val == $past(wr_data)) // R25
      else $error("buffer write did not set valid flag");
   AST_CAP_FIFO: assert property (!cmp_mode && rd && bv && !cap_trig // R26
      |=> val == $past(buf_val) && flag)
      else $error("pending capture did not move into channel");
   COV_OVERRUN: cover property (overrun);
endmodule
`default_nettype wire

// ===== src/tcc_core.sv
// Sixteen-bit timer/counter core with four capture/compare channels
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"
// Overview of operation
// R1: Counting up, counter goes to zero on the tick after reaching top.
// R2: Counting down, counter reloads from period_value on reaching zero.
// R3: Software counter write wins over count, clear, reload; direction changes anytime.
// R4: Event n enables counting, event n+1 picks direction, 1 up, 0 down.
// R5: Quadrature decoded steps from the event system drive the counter.
// R6: For 32 bits, overflow event of low counter clocks the high counter.
// R7: Unbuffered period write takes effect at once.
// R8: Unbuffered period below count while up-counting: counter runs on to wrap.
// R9: Buffered period written anytime, loaded into period_value only on update.
// R10: Software keeps normal operation when counter is capture time base.
// R11: Channel A uses selected event channel, later channels the next ones.
// R12: Capture copies count_value into every enabled channel.
// R13: Period below 0x8000 and pin edge: msb holds polarity, 1 rising.
// R14: Input capture sets channel_flag and buffer_valid_flag as data is held.
// R15: Frequency capture: rising event captures and restarts the counter.
// R16: Software enables only one channel in frequency capture.
// R17: Pulse width capture: rising restarts, falling captures; pin senses both edges.
// R18: Software delays high counter capture one clock in 32-bit capture.
// R19: Capture with both flags set is dropped and raises the error flag.
// R20: Count equal to channel_value sets channel flag next tick, with event.
// R21: Buffered compare values load only at update, top or zero.
// R22: Channel drives pin only with waveform mode, no event action, enabled.
// R23: Top is period_value or channel_a_value as chosen by waveform mode.
// R24: Update fires at zero or top depending on waveform mode.
// R25: Compare buffer write sets buffer_valid_flag; update clears it.
// R26: Empty or read channel takes pending capture buffer, like two-entry FIFO.
module tcc_core (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   // Configuration
   input  wire tcc_pkg::tcc_cfg_t   cfg,
   // Software writes, reads and flag clears
   input  wire tcc_pkg::tcc_wr_t    wr,
   input  wire logic [3:0]          cc_rd,
   input  wire logic [3:0]          cc_flag_clr,
   input  wire logic                err_clr,
   input  wire logic                ovf_clr,
   // Event system
   input  wire logic [7:0]          ev_in,
   input  wire logic [7:0]          ev_pin,
   input  wire logic [7:0]          ev_rise,
   input  wire logic                qdec_step,
   input  wire logic                qdec_up,
   // Counter state
   output logic [15:0]              count_value,
   output logic [15:0]              period_value,
   output logic [15:0]              period_buf,
   output logic                     period_bv,
   output logic                     dir_is_down,
   output logic                     ovf_flag,
   output logic                     ovf_evt,
   output logic                     err_flag,
   // Channel state
   output logic [3:0][15:0]         channel_value,
   output logic [3:0][15:0]         channel_buf,
   output logic [3:0]               buffer_valid_flag,
   output logic [3:0]               channel_flag,
   output logic [3:0]               cc_evt,
   // Waveform pins
   output logic [3:0]               wg_out,
   output logic [3:0]               wg_oe
);
   logic [9:0]  pre_reg;
   logic [9:0]  pre_mask;
   logic        pre_tick;
   logic        base_tick;
   logic        tick;
   logic        down;
   logic        dual_dn_reg;
   logic        ev_ctl;
   logic        cap_mode;
   logic        restart;
   logic        update;
   logic [15:0] top_val;
   logic [15:0] cnt_next;
   logic [2:0]  dir_ev;
   logic [3:0]  cap_trig;
   logic [3:0]  rise_hit;
   logic [3:0]  err_evt;
   logic [15:0] cap_val [4];

   // Shared prescaler: one-cycle enable pulses for each division
   always_ff @(posedge core_clk) begin
      if (sys_rst)
         pre_reg <= `TCC_PRE_ZERO;
      else
         pre_reg <= pre_reg + `TCC_PRE_ONE;
   end

   always_comb begin
      unique case (cfg.clk_sel[2:0])
         3'h1:    pre_mask = `TCC_MASK_DIV1;
         3'h2:    pre_mask = `TCC_MASK_DIV2;
         3'h3:    pre_mask = `TCC_MASK_DIV4;
         3'h4:    pre_mask = `TCC_MASK_DIV8;
         3'h5:    pre_mask = `TCC_MASK_DIV64;
         3'h6:    pre_mask = `TCC_MASK_DIV256;
         default: pre_mask = `TCC_MASK_DIV1K;
      endcase
   end

   assign pre_tick  = (pre_reg & pre_mask) == pre_mask;
   assign base_tick = (cfg.clk_sel == `TCC_CLK_OFF) ? 1'b0 :
                      cfg.clk_sel[3] ? ev_in[cfg.clk_sel[2:0]] : pre_tick;
   assign dir_ev    = cfg.ev_sel + 3'h1;

   // R4 R5: event-controlled counting and direction
   always_comb begin
      tick = base_tick;
      down = cfg.wg_mode == tcc_pkg::WGM_DUAL ? dual_dn_reg : cfg.dir_down;
      if (cfg.ev_act == tcc_pkg::EVACT_UPDOWN) begin
         tick = base_tick && ev_in[cfg.ev_sel];
         down = !ev_in[dir_ev];
      end else if (cfg.ev_act == tcc_pkg::EVACT_QDEC) begin
         tick = qdec_step && (cfg.clk_sel != `TCC_CLK_OFF);
         down = !qdec_up;
      end
   end

   assign ev_ctl   = cfg.ev_act != tcc_pkg::EVACT_OFF;
   assign cap_mode = cfg.ev_act == tcc_pkg::EVACT_CAPT || cfg.ev_act == tcc_pkg::EVACT_FRQ ||
                     cfg.ev_act == tcc_pkg::EVACT_PW;

   // R23: top from channel A in frequency mode
   assign top_val = cfg.wg_mode == tcc_pkg::WGM_FRQ ? channel_value[0] : period_value;

   // R24: update at top or zero by mode
   always_comb begin
      update = 1'b0;
      if (tick) begin
         if (cfg.wg_mode == tcc_pkg::WGM_DUAL)
            update = dual_dn_reg && count_value == `TCC_ZERO;
         else if (down)
            update = count_value == `TCC_ZERO;
         else
            update = count_value == top_val;
      end
   end

   // R11: channel i follows event channel ev_sel+i
   genvar i;
   generate
      for (i = 0; i < `TCC_NCH; i++) begin : g_src
         logic [2:0] src;
         logic       ev;
         assign src = cfg.ev_sel + 3'(i);
         // R12: only enabled channels take the time stamp
         assign ev  = ev_in[src] && cfg.cc_en[i];
         assign rise_hit[i] = ev && ev_rise[src];
         // R15 R17: capture on rise for frequency, fall for pulse width
         assign cap_trig[i] = cfg.ev_act == tcc_pkg::EVACT_CAPT ? ev :
                              cfg.ev_act == tcc_pkg::EVACT_FRQ ? rise_hit[i] :
                              cfg.ev_act == tcc_pkg::EVACT_PW ? ev && !ev_rise[src] : 1'b0;
         // R13: edge polarity in msb for short periods
         assign cap_val[i] = (period_value < `TCC_POL_LIMIT && ev_pin[src]) ?
                             {ev_rise[src], count_value[`TCC_MSB-1:0]} : count_value;
         tcc_chan u_chan (
            .core_clk  (core_clk),
            .sys_rst   (sys_rst),
            .tick      (tick),
            .update    (update),
            .cnt       (count_value),
            .cmp_mode  (!cap_mode),
            .wgm       (cfg.wg_mode),
            .cap_trig  (cap_trig[i]),
            .cap_val   (cap_val[i]),
            .wr_val    (wr.cc_wr[i]),
            .wr_buf    (wr.ccbuf_wr[i]),
            .wr_data   (wr.data),
            .rd        (cc_rd[i]),
            .flag_clr  (cc_flag_clr[i]),
            .val       (channel_value[i]),
            .buf_val   (channel_buf[i]),
            .bv        (buffer_valid_flag[i]),
            .flag      (channel_flag[i]),
            .match_evt (cc_evt[i]),
            .err_evt   (err_evt[i]),
            .wg        (wg_out[i])
         );
         // R22: pin override only in waveform mode without event action
         assign wg_oe[i] = cfg.wg_mode != tcc_pkg::WGM_NORMAL && !ev_ctl && cfg.cc_en[i];
      end
   endgenerate

   // R15 R17: rising event restarts shared counter
   assign restart = (cfg.ev_act == tcc_pkg::EVACT_FRQ || cfg.ev_act == tcc_pkg::EVACT_PW) &&
                    |rise_hit;

   always_comb begin
      cnt_next = count_value;
      if (tick) begin
         if (cfg.wg_mode == tcc_pkg::WGM_DUAL && !dual_dn_reg && count_value == top_val)
            cnt_next = count_value - `TCC_ONE;
         else if (!down)
            // R1 R8: exact match only, so a low new top wraps via max
            cnt_next = count_value == top_val ? `TCC_ZERO : count_value + `TCC_ONE;
         else
            // R2: reload at bottom
            cnt_next = count_value == `TCC_ZERO ? period_value : count_value - `TCC_ONE;
      end
      if (restart)
         cnt_next = `TCC_ZERO;
      // R3: software write has top priority
      if (wr.cnt_wr)
         cnt_next = wr.data;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst)
         count_value <= `TCC_ZERO;
      else
         count_value <= cnt_next;
   end

   // Dual slope flag turns down at top and up at bottom, where the count reloads period_value
   always_ff @(posedge core_clk) begin
      if (sys_rst || cfg.wg_mode != tcc_pkg::WGM_DUAL || restart)
         dual_dn_reg <= 1'b0;
      else if (tick && !dual_dn_reg && count_value == top_val)
         dual_dn_reg <= 1'b1;
      else if (tick && dual_dn_reg && count_value == `TCC_ZERO)
         dual_dn_reg <= 1'b0;
   end

   assign dir_is_down = down;

   // R7 R9: direct write is immediate, buffer loads on update
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         period_value <= `TCC_PER_RST;
         period_buf   <= `TCC_PER_RST;
         period_bv    <= 1'b0;
      end else begin
         if (wr.per_wr)
            period_value <= wr.data;
         else if (update && period_bv)
            period_value <= period_buf;
         if (wr.perbuf_wr) begin
            period_buf <= wr.data;
            period_bv  <= 1'b1;
         end else if (update) begin
            period_bv <= 1'b0;
         end
      end
   end

   // R6: overflow event usable as clock of a cascaded counter
   assign ovf_evt = update;

   // R19: error flag, set wins over clear
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         err_flag <= 1'b0;
         ovf_flag <= 1'b0;
      end else begin
         err_flag <= |err_evt || (err_flag && !err_clr);
         ovf_flag <= update || (ovf_flag && !ovf_clr);
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_UP_WRAP: assert property (tick && !down && cfg.wg_mode != tcc_pkg::WGM_DUAL // R1
      && count_value == top_val && !restart && !wr.cnt_wr |=> count_value == `TCC_ZERO)
      else $error("counter did not clear after top");
   AST_DOWN_RELOAD: assert property (tick && down && count_value == `TCC_ZERO // R2
      && !restart && !wr.cnt_wr |=> count_value == $past(period_value))
      else $error("counter did not reload period at bottom");
   AST_CNT_WR: assert property (wr.cnt_wr |=> count_value == $past(wr.data)) // R3
      else $error("software count write lost");
   AST_PER_DIRECT: assert property (wr.per_wr |=> period_value == $past(wr.data)) // R7
      else $error("period write not immediate");
   AST_CAPTURE_A: assert property (cap_trig[0] && !channel_flag[0] && !wr.cc_wr[0] // R12
      |=> channel_value[0] == $past(cap_val[0]) && channel_flag[0])
      else $error("capture did not store count");
   AST_ERR_SET: assert property (|err_evt |=> err_flag [*2] or ##1 (err_flag ##1 1'b1)) // R19
      else $error("overrun did not raise error flag");
   AST_PER_HOLD: assert property (!wr.per_wr && !update |=> $stable(period_value)) // R9
      else $error("period changed outside update");

   COV_UPDATE_BUF: cover property (update && period_bv);
   COV_FRQ_RESTART: cover property (restart ##[1:20] |cap_trig);
   COV_CMP_MATCH: cover property (|cc_evt);
endmodule
`default_nettype wire

// ===== dv/tcc_evsrc.sv
// Event-system stand-in: one-cycle event strobes and quadrature steps
`timescale 1ns/1ps
`default_nettype none
module tcc_evsrc (
   // Clock
   input  wire logic      core_clk,
   // Event channels toward the core
   output var logic [7:0] ev_in,
   output var logic [7:0] ev_pin,
   output var logic [7:0] ev_rise,
   // Quadrature decoder toward the core
   output var logic       qdec_step,
   output var logic       qdec_up
);
   initial begin
      ev_in = 8'h00;
      ev_pin = 8'h00;
      ev_rise = 8'h00;
      qdec_step = 1'b0;
      qdec_up = 1'b0;
   end
   // pin events carry both edge kinds with their polarity
   task automatic fire(input logic [7:0] m, input logic [7:0] p, input logic [7:0] r);
      ev_in = m;
      ev_pin = p;
      ev_rise = r;
   endtask
   // decoded steps from the event system
   task automatic quad(input logic up);
      qdec_step = 1'b1;
      qdec_up = up;
   endtask
   // single counter here, so no cascade routing or capture delay
   // Qualifiers go stale after a strobe so no one leans on their last value
   always @(posedge core_clk) begin
      ev_in <= 8'h00;
      ev_pin <= ~ev_pin;
      ev_rise <= ~ev_rise;
      qdec_step <= 1'b0;
      qdec_up <= ~qdec_up;
   end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the timer/counter capture-compare core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic              core_clk;
   logic              sys_rst;
   tcc_pkg::tcc_cfg_t cfg;
   tcc_pkg::tcc_wr_t  wr;
   logic [3:0]        cc_rd;
   logic [3:0]        cc_flag_clr;
   logic              err_clr;
   logic              ovf_clr;
   logic [7:0]        ev_in;
   logic [7:0]        ev_pin;
   logic [7:0]        ev_rise;
   logic              qdec_step;
   logic              qdec_up;
   logic [15:0]       count_value;
   logic [15:0]       period_value;
   logic              period_bv;
   logic [15:0]       period_buf;
   logic              dir_is_down;
   logic              ovf_flag;
   logic              err_flag;
   logic [3:0][15:0]  channel_value;
   logic [3:0]        buffer_valid_flag;
   logic [3:0]        channel_flag;
   logic [3:0]        wg_oe;
   int                n_fail;
   int                n_checks;
   int                qk[$];
   logic [15:0]       qv[$];
   logic [2:0]        s;
   logic [15:0]       v;
   logic [7:0]        ma;
   logic [7:0]        mb;

   tcc_core DUT (.core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg), .wr(wr), .cc_rd(cc_rd),
      .cc_flag_clr(cc_flag_clr), .err_clr(err_clr), .ovf_clr(ovf_clr), .ev_in(ev_in),
      .ev_pin(ev_pin), .ev_rise(ev_rise), .qdec_step(qdec_step), .qdec_up(qdec_up),
      .count_value(count_value), .period_value(period_value), .period_buf(period_buf),
      .period_bv(period_bv), .dir_is_down(dir_is_down), .ovf_flag(ovf_flag), .ovf_evt(),
      .err_flag(err_flag), .channel_value(channel_value), .channel_buf(),
      .buffer_valid_flag(buffer_valid_flag), .channel_flag(channel_flag), .cc_evt(),
      .wg_out(), .wg_oe(wg_oe));

   tcc_evsrc EVS (.core_clk(core_clk), .ev_in(ev_in), .ev_pin(ev_pin), .ev_rise(ev_rise),
      .qdec_step(qdec_step), .qdec_up(qdec_up));

   task automatic stop_test();
      $display("Counts: %0d checks, %0d mismatches", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmpf(input string nm, input logic [3:0] e, input logic [3:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask
   // Kinds: 0 count, 1 period, 2 period bv, 3 ovf, 4 err, 5..8 channel, 9 flags, 10 bv, 11 oe
   task automatic check(input int k, input logic [15:0] e);
      case (k)
         0: cmp16("count_value", e, count_value);
         1: cmp16("period_value", e, period_value);
         2: cmpf("period_bv", e[3:0], {3'h0, period_bv});
         3: cmpf("ovf_flag", e[3:0], {3'h0, ovf_flag});
         4: cmpf("err_flag", e[3:0], {3'h0, err_flag});
         9: cmpf("channel_flag", e[3:0], channel_flag);
         10: cmpf("buffer_valid_flag", e[3:0], buffer_valid_flag);
         11: cmpf("wg_oe", e[3:0], wg_oe);
         12: cmp16("period_buf", e, period_buf);
         13: cmpf("dir_is_down", e[3:0], {3'h0, dir_is_down});
         default: cmp16("channel_value", e, channel_value[k-5]);
      endcase
   endtask
   task automatic note(input int k, input logic [15:0] e);
      qk.push_back(k);
      qv.push_back(e);
   endtask
   // Strobes last exactly one cycle
   task automatic step();
      @(negedge core_clk);
      wr = '0;
      cc_rd = 4'h0;
      cc_flag_clr = 4'h0;
      err_clr = 1'b0;
      ovf_clr = 1'b0;
   endtask
   task automatic done(input string t);
      $display("Test %s finished", t);
   endtask

   // Notes made at a falling edge are judged just after the next rising edge
   always @(posedge core_clk) begin
      #1;
      while (qk.size() > 0) begin
         check(qk.pop_front(), qv.pop_front());
      end
   end

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      n_fail++;
      stop_test();
   end

   initial begin
      sys_rst = 1'b1;
      cfg = '0;
      wr = '0;
      cc_rd = 4'h0;
      cc_flag_clr = 4'h0;
      err_clr = 1'b0;
      ovf_clr = 1'b0;
      n_fail = 0;
      n_checks = 0;
      v = 16'($urandom(32'h917a3b16));
      s = 3'($urandom);
      repeat (16) @(negedge core_clk);
      note(1, 16'hffff);
      sys_rst = 1'b0;
      step();
      wr.cnt_wr = 1'b1;
      wr.per_wr = 1'b1;
      wr.data = 16'h0003;
      note(1, 16'h0003);
      step();
      cfg.clk_sel = 4'h1;
      note(0, 16'h0000);
      note(3, 16'h0001);
      repeat (3) step();
      v = 16'($urandom_range(2));
      wr.cnt_wr = 1'b1;
      wr.data = v;
      note(0, v);
      step();
      note(0, v + 16'h0001);
      step();
      cfg.dir_down = 1'b1;
      wr.cnt_wr = 1'b1;
      wr.data = 16'h0001;
      ovf_clr = 1'b1;
      note(3, 16'h0000);
      step();
      note(0, 16'h0000);
      note(13, 16'h0001);
      step();
      note(0, 16'h0003);
      note(3, 16'h0001);
      step();
      note(0, 16'h0002);
      step();
      cfg.dir_down = 1'b0;
      wr.per_wr = 1'b1;
      wr.data = 16'h0010;
      note(1, 16'h0010);
      step();
      wr.cnt_wr = 1'b1;
      wr.data = 16'hfffd;
      step();
      note(0, 16'hfffe);
      repeat (2) step();
      note(0, 16'h0000);
      step();
      wr.perbuf_wr = 1'b1;
      wr.data = 16'h0005;
      note(2, 16'h0001);
      note(12, 16'h0005);
      note(1, 16'h0010);
      step();
      wr.cnt_wr = 1'b1;
      wr.data = 16'h000f;
      repeat (2) step();
      note(1, 16'h0005);
      note(2, 16'h0000);
      done("period");
      step();
      cfg.clk_sel = 4'h0;
      cc_flag_clr = 4'hf;
      wr.cnt_wr = 1'b1;
      wr.data = 16'h0000;
      step();
      wr.cc_wr = 4'b0010;
      wr.data = 16'h0002;
      step();
      wr.ccbuf_wr = 4'b0100;
      wr.data = 16'h0004;
      note(10, 16'h0004);
      step();
      cfg.clk_sel = 4'h1;
      note(9, 16'h000d);
      step();
      note(9, 16'h000d);
      step();
      note(9, 16'h000f);
      repeat (2) step();
      note(7, 16'h0000);
      step();
      note(7, 16'h0004);
      note(10, 16'h0000);
      step();
      cfg.clk_sel = 4'h0;
      cc_flag_clr = 4'hf;
      note(9, 16'h0000);
      for (int m = 0; m < 4; m++) begin
         step();
         cfg.wg_mode = tcc_pkg::tcc_wgm_t'(2'(m));
         cfg.cc_en = 4'h5;
         note(11, (m == 0) ? 16'h0000 : 16'h0005);
      end
      step();
      cfg.ev_act = tcc_pkg::EVACT_CAPT;
      note(11, 16'h0000);
      done("compare");
      step();
      // counter left in normal operation as capture time base
      cfg.wg_mode = tcc_pkg::WGM_NORMAL;
      cfg.cc_en = 4'b0010;
      cfg.ev_sel = s;
      wr.cnt_wr = 1'b1;
      wr.data = 16'h0042;
      ma = 8'h01 << s;
      mb = 8'h01 << 3'(s + 3'h1);
      step();
      EVS.fire(ma | mb, mb, mb);
      note(6, 16'h8042);
      note(5, 16'h0000);
      note(9, 16'h0002);
      step();
      EVS.fire(mb, mb, 8'h00);
      note(10, 16'h0002);
      step();
      EVS.fire(mb, 8'h00, 8'h00);
      note(4, 16'h0001);
      note(6, 16'h8042);
      step();
      cc_rd = 4'b0010;
      note(6, 16'h0042);
      note(10, 16'h0000);
      note(9, 16'h0002);
      step();
      cc_rd = 4'b0010;
      err_clr = 1'b1;
      note(9, 16'h0000);
      note(4, 16'h0000);
      done("capture");
      step();
      cfg.ev_act = tcc_pkg::EVACT_FRQ;
      // a single capture channel restarts the shared counter
      cfg.cc_en = 4'b0001;
      cfg.clk_sel = 4'h1;
      wr.cnt_wr = 1'b1;
      wr.data = 16'h0020;
      step();
      EVS.fire(ma, ma, ma);
      note(5, 16'h8020);
      note(0, 16'h0000);
      step();
      cfg.ev_act = tcc_pkg::EVACT_PW;
      cc_flag_clr = 4'b0001;
      step();
      EVS.fire(ma, ma, ma);
      note(0, 16'h0000);
      repeat (2) step();
      EVS.fire(ma, ma, 8'h00);
      note(5, 16'h0001);
      note(0, 16'h0002);
      step();
      cfg.ev_act = tcc_pkg::EVACT_UPDOWN;
      wr.cnt_wr = 1'b1;
      wr.data = 16'h0010;
      step();
      EVS.fire(ma, 8'h00, 8'h00);
      note(0, 16'h000f);
      step();
      EVS.fire(ma | mb, 8'h00, 8'h00);
      note(0, 16'h0010);
      step();
      note(0, 16'h0010);
      step();
      cfg.ev_act = tcc_pkg::EVACT_QDEC;
      EVS.quad(1'b1);
      note(0, 16'h0011);
      step();
      EVS.quad(1'b0);
      note(0, 16'h0010);
      done("events");
      step();
      stop_test();
   end
endmodule
`default_nettype wire
